/* design/dsc_pkg.sv */
package dsc_pkg;

  localparam int unsigned DSC_ADDR_W = 13;
  localparam int unsigned DSC_DATA_W = 32;

  // Byte offsets of the register map.
  localparam logic [12:0] DSC_OFS_TRIGGER = 13'h0000;
  localparam logic [12:0] DSC_OFS_STICKY = 13'h0001;
  localparam logic [12:0] DSC_OFS_LIVE = 13'h0002;
  localparam logic [12:0] DSC_OFS_OPADDR = 13'h0004;
  localparam logic [12:0] DSC_OFS_MAILBOX0 = 13'h0010;
  localparam logic [12:0] DSC_OFS_MAILBOX1 = 13'h0014;
  localparam logic [12:0] DSC_OFS_PIDENT0 = 13'h1FE0;
  localparam logic [12:0] DSC_OFS_PIDENT1 = 13'h1FE4;
  localparam logic [12:0] DSC_OFS_PIDENT2 = 13'h1FE8;
  localparam logic [12:0] DSC_OFS_PIDENT3 = 13'h1FEC;
  localparam logic [12:0] DSC_OFS_CIDENT0 = 13'h1FF0;
  localparam logic [12:0] DSC_OFS_CIDENT1 = 13'h1FF4;
  localparam logic [12:0] DSC_OFS_CIDENT2 = 13'h1FF8;
  localparam logic [12:0] DSC_OFS_CIDENT3 = 13'h1FFC;

  // Byte lanes inside word 0.
  localparam int unsigned DSC_LANE_TRIGGER = 0;
  localparam int unsigned DSC_LANE_STICKY = 1;
  localparam int unsigned DSC_LANE_LIVE = 2;

  // Trigger register bits.
  localparam int unsigned DSC_TRG_ERASE = 4;
  localparam int unsigned DSC_TRG_SELFTEST = 3;
  localparam int unsigned DSC_TRG_CRC = 2;
  localparam int unsigned DSC_TRG_SOFTRST = 0;

  // Sticky status bits.
  localparam int unsigned DSC_STK_PROTVIOL = 4;
  localparam int unsigned DSC_STK_FAIL = 3;
  localparam int unsigned DSC_STK_BUSFAULT = 2;
  localparam int unsigned DSC_STK_RSTSTRETCH = 1;
  localparam int unsigned DSC_STK_DONE = 0;
  localparam logic [7:0] DSC_STK_MASK = 8'h1F;

  // Live status bits.
  localparam int unsigned DSC_LIV_HOTPLUG = 4;
  localparam int unsigned DSC_LIV_MBOX1 = 3;
  localparam int unsigned DSC_LIV_MBOX0 = 2;
  localparam int unsigned DSC_LIV_DBG = 1;
  localparam int unsigned DSC_LIV_SECURED = 0;

  // Operation address fields.
  localparam int unsigned DSC_OPA_WORD_LSB = 2;
  localparam int unsigned DSC_OPA_MODE_MSB = 1;

  // Reset values.
  localparam logic [7:0] DSC_RST_STICKY = 8'h00;
  localparam logic [31:0] DSC_RST_OPADDR = 32'h0000_0000;
  localparam logic [31:0] DSC_RST_MAILBOX = 32'h0000_0000;
  localparam logic [31:0] DSC_RST_RDATA = 32'h0000_0000;
  localparam logic DSC_RST_HOTPLUG = 1'b1;

  typedef struct packed {
    logic [12:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } dsc_bus_req_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic bus_err;
  } dsc_engine_evt_t;

  typedef struct packed {
    logic erase;
    logic selftest;
    logic crc;
    logic soft_reset;
  } dsc_launch_t;

  typedef enum logic {
    DSC_ST_CAPTURE,
    DSC_ST_RUN
  } dsc_phase_t;

endpackage : dsc_pkg

/* design/dsc_service_unit.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module dsc_service_unit
  import dsc_pkg::*;
#(
  // Identification values are arbitrary.
  parameter logic [31:0] PIDENT0_VAL = 32'h0000_0011,
  parameter logic [31:0] PIDENT1_VAL = 32'h0000_0022,
  parameter logic [31:0] PIDENT2_VAL = 32'h0000_0033,
  parameter logic [31:0] PIDENT3_VAL = 32'h0000_0044,
  parameter logic [31:0] CIDENT0_VAL = 32'h0000_0055,
  parameter logic [31:0] CIDENT1_VAL = 32'h0000_0066,
  parameter logic [31:0] CIDENT2_VAL = 32'h0000_0077,
  parameter logic [31:0] CIDENT3_VAL = 32'h0000_0088
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire dsc_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic guard_protect,
  input wire logic device_protected,
  input wire logic swclk_func_changed,
  input wire logic probe_detect_pin,
  input wire logic cold_plug_pin,
  input wire dsc_engine_evt_t engine_evt,
  output dsc_launch_t launch,
  output logic [29:0] op_word_addr,
  output logic [1:0] access_mode_field
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    dsc_phase_t phase;
    logic [1:0] probe_sync;
    logic [1:0] cold_sync;
    logic [7:0] sticky_status_reg;
    logic hot_plug_allowed;
    logic mailbox0_dirty;
    logic mailbox1_dirty;
    logic debugger_attached;
    logic secured_state_flag;
    logic [31:0] opaddr_reg;
    logic [31:0] mailbox0_reg;
    logic [31:0] mailbox1_reg;
    logic [31:0] rdata_reg;
    dsc_launch_t launch_reg;
  } dsc_state_t;

  dsc_state_t state_reg;
  dsc_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merges the enabled byte lanes of new data into an old word.
  function automatic logic [31:0] dsc_merge(input logic [31:0] old_word, input logic [31:0] new_word,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction : dsc_merge

  // True when the access hits the aligned word holding the given offset.
  function automatic logic dsc_hit(input logic [12:0] addr, input logic [12:0] ofs);
    return addr[12:2] == ofs[12:2];
  endfunction : dsc_hit

  // True when a write strobe hits the word holding the given offset.
  function automatic logic dsc_wr_hit(input dsc_bus_req_t req, input logic [12:0] ofs);
    return req.wr && dsc_hit(req.addr, ofs);
  endfunction : dsc_wr_hit

  // True when a read strobe hits the word holding the given offset.
  function automatic logic dsc_rd_hit(input dsc_bus_req_t req, input logic [12:0] ofs);
    return req.rd && dsc_hit(req.addr, ofs);
  endfunction : dsc_rd_hit

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    logic wr_word0;
    logic [7:0] trig_wr;
    logic [7:0] stk_clr;
    logic [7:0] stk_set;
    logic want_selftest;
    logic want_crc;
    logic want_erase;
    logic do_softrst;
    logic guard_ok;
    logic probe_seen;
    logic cold_seen;
    logic secured_now;
    logic [31:0] rd_word;

    wr_word0 = 1'b0;
    trig_wr = 8'h00;
    stk_clr = 8'h00;
    stk_set = 8'h00;
    want_selftest = 1'b0;
    want_crc = 1'b0;
    want_erase = 1'b0;
    do_softrst = 1'b0;
    rd_word = 32'h0000_0000;
    guard_ok = 1'b0;
    probe_seen = 1'b0;
    cold_seen = 1'b0;
    secured_now = 1'b0;
    state_next = state_reg;

    // Only the second flip-flop of each synchroniser is read.
    probe_seen = state_reg.probe_sync[1];
    cold_seen = state_reg.cold_sync[1];
    state_next.probe_sync = {state_reg.probe_sync[0], probe_detect_pin};
    state_next.cold_sync = {state_reg.cold_sync[0], cold_plug_pin};

    // Launch strobes last one cycle.
    state_next.launch_reg = '0;

    guard_ok = !guard_protect;

    wr_word0 = dsc_wr_hit(bus_req, DSC_OFS_TRIGGER) && guard_ok;
    if (wr_word0 && bus_req.be[DSC_LANE_TRIGGER])
    begin
      trig_wr = bus_req.wdata[8*DSC_LANE_TRIGGER +: 8];
    end
    if (wr_word0 && bus_req.be[DSC_LANE_STICKY])
    begin
      stk_clr = bus_req.wdata[8*DSC_LANE_STICKY +: 8] & DSC_STK_MASK;
    end

    want_erase = trig_wr[DSC_TRG_ERASE];
    want_selftest = trig_wr[DSC_TRG_SELFTEST];
    want_crc = trig_wr[DSC_TRG_CRC];
    do_softrst = trig_wr[DSC_TRG_SOFTRST];

    // The strap already counts in the capture cycle, so an early command cannot slip past it.
    secured_now = state_reg.secured_state_flag;
    if (state_reg.phase == DSC_ST_CAPTURE)
    begin
      secured_now = device_protected;
    end

    if (secured_now && (want_selftest || want_crc))
    begin
      stk_set[DSC_STK_PROTVIOL] = 1'b1;
      want_selftest = 1'b0;
      want_crc = 1'b0;
    end
    stk_set[DSC_STK_FAIL] = engine_evt.fail;
    stk_set[DSC_STK_BUSFAULT] = engine_evt.bus_err;
    stk_set[DSC_STK_RSTSTRETCH] = cold_seen;
    stk_set[DSC_STK_DONE] = engine_evt.done;

    // Setting wins over a clear that arrives in the same cycle.
    state_next.sticky_status_reg = ((state_reg.sticky_status_reg & ~stk_clr) | stk_set) & DSC_STK_MASK;

    state_next.launch_reg.erase = want_erase;
    state_next.launch_reg.selftest = want_selftest;
    state_next.launch_reg.crc = want_crc;
    state_next.launch_reg.soft_reset = do_softrst;

    if (dsc_wr_hit(bus_req, DSC_OFS_OPADDR) && guard_ok)
    begin
      state_next.opaddr_reg = dsc_merge(state_reg.opaddr_reg, bus_req.wdata, bus_req.be);
    end

    if (dsc_wr_hit(bus_req, DSC_OFS_MAILBOX0))
    begin
      state_next.mailbox0_reg = dsc_merge(state_reg.mailbox0_reg, bus_req.wdata, bus_req.be);
      state_next.mailbox0_dirty = 1'b1;
    end
    else if (dsc_rd_hit(bus_req, DSC_OFS_MAILBOX0))
    begin
      state_next.mailbox0_dirty = 1'b0;
    end
    if (dsc_wr_hit(bus_req, DSC_OFS_MAILBOX1))
    begin
      state_next.mailbox1_reg = dsc_merge(state_reg.mailbox1_reg, bus_req.wdata, bus_req.be);
      state_next.mailbox1_dirty = 1'b1;
    end
    else if (dsc_rd_hit(bus_req, DSC_OFS_MAILBOX1))
    begin
      state_next.mailbox1_dirty = 1'b0;
    end

    if (swclk_func_changed)
    begin
      state_next.hot_plug_allowed = 1'b0;
    end

    if (probe_seen)
    begin
      state_next.debugger_attached = 1'b1;
    end

    case (state_reg.phase)
      DSC_ST_CAPTURE:
      begin
        state_next.secured_state_flag = device_protected;
        state_next.phase = DSC_ST_RUN;
      end
      DSC_ST_RUN:
      begin
        state_next.phase = DSC_ST_RUN;
      end
      default:
      begin
        state_next.phase = DSC_ST_RUN;
      end
    endcase

    // Hot-plug, debugger and secured flags keep their values, since only a full reset may restore them.
    // Soft reset restore
    if (do_softrst)
    begin
      state_next.sticky_status_reg = DSC_RST_STICKY;
      state_next.opaddr_reg = DSC_RST_OPADDR;
      state_next.mailbox0_reg = DSC_RST_MAILBOX;
      state_next.mailbox1_reg = DSC_RST_MAILBOX;
      state_next.mailbox0_dirty = 1'b0;
      state_next.mailbox1_dirty = 1'b0;
      state_next.launch_reg.erase = 1'b0;
      state_next.launch_reg.selftest = 1'b0;
      state_next.launch_reg.crc = 1'b0;
    end

    // Unmapped words and the write-only trigger lane read as zero.
    // Word read with all lanes
    if (dsc_hit(bus_req.addr, DSC_OFS_TRIGGER))
    begin
      rd_word[8*DSC_LANE_LIVE + DSC_LIV_HOTPLUG] = state_reg.hot_plug_allowed;
      rd_word[8*DSC_LANE_LIVE + DSC_LIV_MBOX1] = state_reg.mailbox1_dirty;
      rd_word[8*DSC_LANE_LIVE + DSC_LIV_MBOX0] = state_reg.mailbox0_dirty;
      rd_word[8*DSC_LANE_LIVE + DSC_LIV_DBG] = state_reg.debugger_attached;
      rd_word[8*DSC_LANE_LIVE + DSC_LIV_SECURED] = state_reg.secured_state_flag;
      rd_word[8*DSC_LANE_STICKY +: 8] = state_reg.sticky_status_reg;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_OPADDR))
    begin
      rd_word = state_reg.opaddr_reg;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_MAILBOX0))
    begin
      rd_word = state_reg.mailbox0_reg;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_MAILBOX1))
    begin
      rd_word = state_reg.mailbox1_reg;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_PIDENT0))
    begin
      rd_word = PIDENT0_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_PIDENT1))
    begin
      rd_word = PIDENT1_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_PIDENT2))
    begin
      rd_word = PIDENT2_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_PIDENT3))
    begin
      rd_word = PIDENT3_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_CIDENT0))
    begin
      rd_word = CIDENT0_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_CIDENT1))
    begin
      rd_word = CIDENT1_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_CIDENT2))
    begin
      rd_word = CIDENT2_VAL;
    end
    else if (dsc_hit(bus_req.addr, DSC_OFS_CIDENT3))
    begin
      rd_word = CIDENT3_VAL;
    end

    // Read data stands only in the cycle after the read strobe.
    state_next.rdata_reg = bus_req.rd ? rd_word : DSC_RST_RDATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg.phase <= DSC_ST_CAPTURE;
      state_reg.probe_sync <= 2'b00;
      state_reg.cold_sync <= 2'b00;
      state_reg.sticky_status_reg <= DSC_RST_STICKY;
      state_reg.hot_plug_allowed <= DSC_RST_HOTPLUG;
      state_reg.mailbox0_dirty <= 1'b0;
      state_reg.mailbox1_dirty <= 1'b0;
      state_reg.debugger_attached <= 1'b0;
      state_reg.secured_state_flag <= 1'b0;
      state_reg.opaddr_reg <= DSC_RST_OPADDR;
      state_reg.mailbox0_reg <= DSC_RST_MAILBOX;
      state_reg.mailbox1_reg <= DSC_RST_MAILBOX;
      state_reg.rdata_reg <= DSC_RST_RDATA;
      state_reg.launch_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rdata = state_reg.rdata_reg;
  assign launch = state_reg.launch_reg;
  assign op_word_addr = state_reg.opaddr_reg[31:DSC_OPA_WORD_LSB];
  assign access_mode_field = state_reg.opaddr_reg[DSC_OPA_MODE_MSB:0];

endmodule : dsc_service_unit

/* testbench/dsc_service_unit_assertions.sv */
`timescale 1ns/1ps
module dsc_service_unit_checker
  import dsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire dsc_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  input wire logic guard_protect,
  input wire logic device_protected,
  input wire logic swclk_func_changed,
  input wire logic probe_detect_pin,
  input wire logic cold_plug_pin,
  input wire dsc_engine_evt_t engine_evt,
  input wire dsc_launch_t launch,
  input wire logic [29:0] op_word_addr,
  input wire logic [1:0] access_mode_field
);
  logic trg_wr;
  logic opa_wr;
  // Writes to the trigger lane and the operation address that the guard lets through.
  assign trg_wr = bus_req.wr && bus_req.addr[12:2] == 11'h000 && bus_req.be[0] && !guard_protect;
  assign opa_wr = bus_req.wr && bus_req.addr[12:2] == 11'h001 && !guard_protect;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  erase_launch_a: assert property (trg_wr && bus_req.wdata[4] |=> launch.erase)
    else $error("erase write gave no launch pulse");
  selftest_quiet_a: assert property (!(trg_wr && bus_req.wdata[3]) |=> !launch.selftest)
    else $error("self-test launched without a trigger write");
  crc_quiet_a: assert property (!(trg_wr && bus_req.wdata[2]) |=> !launch.crc)
    else $error("checksum launched without a trigger write");
  softrst_launch_a: assert property (trg_wr && bus_req.wdata[0] |=> launch.soft_reset)
    else $error("soft reset write gave no pulse");
  rdata_idle_a: assert property (!bus_req.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside a read answer");
  guard_hold_a: assert property (guard_protect && bus_req.wr
    |=> $stable({op_word_addr, access_mode_field}))
    else $error("guarded write changed the operation address");
  opaddr_load_a: assert property (opa_wr && bus_req.be == 4'hF
    |=> {op_word_addr, access_mode_field} == $past(bus_req.wdata))
    else $error("operation address did not take the written word");
  softrst_clear_a: assert property (launch.soft_reset
    |-> ##[0:1] {op_word_addr, access_mode_field} == 32'h0000_0000)
    else $error("soft reset left the operation address");
endmodule : dsc_service_unit_checker

bind dsc_service_unit dsc_service_unit_checker chk (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .guard_protect(guard_protect), .device_protected(device_protected), .swclk_func_changed(swclk_func_changed),
  .probe_detect_pin(probe_detect_pin), .cold_plug_pin(cold_plug_pin), .engine_evt(engine_evt), .launch(launch),
  .op_word_addr(op_word_addr), .access_mode_field(access_mode_field));

/* testbench/dsc_probe_model.sv */
`timescale 1ns/1ps
module dsc_probe_model (
  input wire logic mclk,
  input wire logic plug_cmd,
  input wire logic cold_cmd,
  output logic probe_detect_pin,
  output logic cold_plug_pin
);
  always_ff @(posedge mclk) probe_detect_pin <= plug_cmd;
  always_ff @(posedge mclk) cold_plug_pin <= cold_cmd;
endmodule : dsc_probe_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import dsc_pkg::*;
;
  logic mclk;
  logic rst;
  dsc_bus_req_t bus_req;
  logic [31:0] rdata;
  logic guard_protect, device_protected, swclk_func_changed, plug_cmd, cold_cmd, probe_detect_pin, cold_plug_pin;
  dsc_engine_evt_t engine_evt;
  dsc_launch_t launch;
  logic [29:0] op_word_addr;
  logic [1:0] access_mode_field;
  int miscompares, compares, cycles;

  dsc_service_unit dut (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .guard_protect(guard_protect),
    .device_protected(device_protected), .swclk_func_changed(swclk_func_changed), .probe_detect_pin(probe_detect_pin),
    .cold_plug_pin(cold_plug_pin), .engine_evt(engine_evt), .launch(launch), .op_word_addr(op_word_addr),
    .access_mode_field(access_mode_field));
  dsc_probe_model probe (.mclk(mclk), .plug_cmd(plug_cmd), .cold_cmd(cold_cmd), .probe_detect_pin(probe_detect_pin),
    .cold_plug_pin(cold_plug_pin));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    bus_req <= '{a, d, be, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [12:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_req <= '{a, 32'h0000_0000, 4'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rdchk

  task automatic pulse_evt(input logic [2:0] e);
    @(posedge mclk);
    engine_evt <= e;
    @(posedge mclk);
    engine_evt <= 3'b000;
  endtask : pulse_evt

  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : do_reset

  task automatic t_regs;
    rdchk(13'h0000, 32'h0010_0000);
    rdchk(13'h0004, 32'h0000_0000);
    rdchk(13'h0100, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
      rdchk(13'h1FE0 + 13'(4 * i), 32'h0000_0011 * (i + 1));
    $display("regs done");
  endtask : t_regs

  task automatic t_launch;
    for (int i = 2; i < 5; i++)
    begin
      wr(13'h0000, 32'h1 << i, 4'h1);
      chk({28'h000_0000, launch}, 32'h1 << (i - 1));
      wr(13'h0000, 32'h0000_0000, 4'h1);
      chk({28'h000_0000, launch}, 32'h0000_0000);
    end
    rdchk(13'h0000, 32'h0010_0000);
    $display("launch done");
  endtask : t_launch

  task automatic t_sticky;
    pulse_evt(3'b111);
    rdchk(13'h0000, 32'h0010_0D00);
    wr(13'h0000, 32'h0000_0000, 4'h2);
    rdchk(13'h0000, 32'h0010_0D00);
    wr(13'h0000, 32'h0000_0100, 4'h2);
    rdchk(13'h0000, 32'h0010_0C00);
    wr(13'h0000, 32'h0000_0C00, 4'h2);
    rdchk(13'h0000, 32'h0010_0000);
    @(posedge mclk);
    cold_cmd <= 1'b1;
    @(posedge mclk);
    cold_cmd <= 1'b0;
    repeat (5) @(posedge mclk);
    rdchk(13'h0000, 32'h0010_0200);
    wr(13'h0000, 32'h0000_0200, 4'h2);
    rdchk(13'h0000, 32'h0010_0000);
    $display("sticky done");
  endtask : t_sticky

  task automatic t_guard;
    @(posedge mclk);
    guard_protect <= 1'b1;
    wr(13'h0004, 32'hFFFF_FFFF, 4'hF);
    rdchk(13'h0004, 32'h0000_0000);
    wr(13'h0000, 32'h0000_0004, 4'h1);
    chk({28'h000_0000, launch}, 32'h0000_0000);
    @(posedge mclk);
    guard_protect <= 1'b0;
    wr(13'h0004, 32'h1234_5678, 4'hF);
    rdchk(13'h0004, 32'h1234_5678);
    wr(13'h0004, 32'hFFFF_FF03, 4'h1);
    rdchk(13'h0004, 32'h1234_5603);
    wr(13'h0004, 32'hABCD_0000, 4'hC);
    rdchk(13'h0004, 32'hABCD_5603);
    chk({op_word_addr, access_mode_field}, 32'hABCD_5603);
    $display("guard done");
  endtask : t_guard

  task automatic t_mbox;
    for (int m = 0; m < 2; m++)
    begin
      wr(13'h0010 + 13'(4 * m), 32'hA5A5_0001, 4'hF);
      rdchk(13'h0000, 32'h0010_0000 | (32'h0004_0000 << m));
      rdchk(13'h0010 + 13'(4 * m), 32'hA5A5_0001);
      rdchk(13'h0000, 32'h0010_0000);
    end
    $display("mailbox done");
  endtask : t_mbox

  task automatic t_persist;
    @(posedge mclk);
    plug_cmd <= 1'b1;
    repeat (6) @(posedge mclk);
    rdchk(13'h0000, 32'h0012_0000);
    wr(13'h0000, 32'h00FF_0000, 4'h4);
    rdchk(13'h0000, 32'h0012_0000);
    @(posedge mclk);
    swclk_func_changed <= 1'b1;
    @(posedge mclk);
    swclk_func_changed <= 1'b0;
    rdchk(13'h0000, 32'h0002_0000);
    pulse_evt(3'b100);
    wr(13'h0000, 32'h0000_0001, 4'h1);
    chk({28'h000_0000, launch}, 32'h0000_0001);
    rdchk(13'h0000, 32'h0002_0000);
    rdchk(13'h0004, 32'h0000_0000);
    rdchk(13'h0010, 32'h0000_0000);
    $display("persist done");
  endtask : t_persist

  task automatic t_secure;
    @(posedge mclk);
    plug_cmd <= 1'b0;
    device_protected <= 1'b1;
    do_reset();
    rdchk(13'h0000, 32'h0011_0000);
    wr(13'h0000, 32'h0000_0004, 4'h1);
    chk({28'h000_0000, launch}, 32'h0000_0000);
    rdchk(13'h0000, 32'h0011_1000);
    wr(13'h0000, 32'h0000_0010, 4'h1);
    chk({28'h000_0000, launch}, 32'h0000_0008);
    wr(13'h0000, 32'h0000_0008, 4'h1);
    chk({28'h000_0000, launch}, 32'h0000_0000);
    wr(13'h0000, 32'h0000_1000, 4'h2);
    rdchk(13'h0000, 32'h0011_0000);
    $display("secure done");
  endtask : t_secure

  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    guard_protect = 1'b0;
    device_protected = 1'b0;
    swclk_func_changed = 1'b0;
    plug_cmd = 1'b0;
    cold_cmd = 1'b0;
    engine_evt = '0;
    do_reset();
    t_regs();
    t_launch();
    t_sticky();
    t_guard();
    t_mbox();
    t_persist();
    t_secure();
    results();
  end
endmodule : tb_top
